// ===== common/srl_pkg.sv
// **********************************************************************
// Set-reset latch unit constants
// **********************************************************************
package srl_pkg;

  // Register bus widths
  localparam int SRL_DATA_W = 8;
  localparam int SRL_ADDR_W = 2;

  // Register indices on the local register port
  localparam logic [1:0] SRL_ADDR_CTRL = 2'h0;
  localparam logic [1:0] SRL_ADDR_SRC = 2'h1;
  localparam logic [1:0] SRL_ADDR_STAT = 2'h2;

  // Reset values of both control registers
  localparam logic [7:0] SRL_CTRL_RST = 8'h00;
  localparam logic [7:0] SRL_SRC_RST = 8'h00;

  // Primary control field positions
  localparam int SRL_B_LEN = 7;
  localparam int SRL_B_DIV_HI = 6;
  localparam int SRL_B_DIV_LO = 4;
  localparam int SRL_B_QEN = 3;
  localparam int SRL_B_NQEN = 2;
  localparam int SRL_B_PS = 1;
  localparam int SRL_B_PR = 0;

  // Source enable field positions
  localparam int SRL_B_PIN_SET = 7;
  localparam int SRL_B_CLK_SET = 6;
  localparam int SRL_B_C2_SET = 5;
  localparam int SRL_B_C1_SET = 4;
  localparam int SRL_B_PIN_RST = 3;
  localparam int SRL_B_CLK_RST = 2;
  localparam int SRL_B_C2_RST = 1;
  localparam int SRL_B_C1_RST = 0;

  // Status field positions
  localparam int SRL_B_ST_Q = 0;
  localparam int SRL_B_ST_PIN = 1;
  localparam int SRL_B_ST_C1 = 2;
  localparam int SRL_B_ST_C2 = 3;
  localparam int SRL_B_ST_DIV = 4;

  // Divider: code 000 gives every 4th cycle, code 111 every 512th
  localparam int SRL_DIV_BASE_LOG2 = 2;
  localparam int SRL_DIV_W = 9;

  // Input synchroniser depth and software pulse length in cycles
  localparam int SRL_SYNC_STAGES = 3;
  localparam int SRL_PULSE_CYCLES = 1;

endpackage

// ===== common/srl_div_if.sv
`timescale 1ns/1ps
// **********************************************************************
// Divider select and divided pulse between control and divider
// **********************************************************************
interface srl_div_if;
  logic [2:0] sel;  // Divider code from the primary control register
  logic pulse;      // One-cycle divided pulse
  modport ctrl (output sel, input pulse);
  modport div (input sel, output pulse);
endinterface

// ===== src/srl_divider.sv
`timescale 1ns/1ps
// **********************************************************************
// Pulse clock divider
// **********************************************************************
module srl_divider
  import srl_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  srl_div_if.div dv
);

  // Free-running cycle counter
  logic [SRL_DIV_W-1:0] count;
  // Low bits that must all be one for a pulse
  logic [SRL_DIV_W-1:0] mask;
  logic [SRL_DIV_W-1:0] next_count;

  // Mask bit i is set while i is below code plus base
  genvar gi;
  generate
    for (gi = 0; gi < SRL_DIV_W; gi++)
    begin : g_mask
      assign mask[gi] = (gi < (int'(dv.sel) + SRL_DIV_BASE_LOG2));
    end
  endgenerate

  assign next_count = count + 9'h001;
  // One cycle wide, once per 4 << code cycles
  assign dv.pulse = ((count & mask) == mask);

  // Counter advances only while the clock enable is high
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      count <= 9'h000;
    else if (clk_en)
      count <= next_count;
  end

  // **********************************************************************
  // Checks
  // **********************************************************************
  // Cycles since the last pulse, and whether the code moved meanwhile
  logic [10:0] gap;
  logic seen;
  logic sel_moved;
  logic [2:0] last_sel;
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      gap <= 11'h000;
      seen <= 1'b0;
      sel_moved <= 1'b0;
      last_sel <= 3'h0;
    end
    else if (clk_en)
    begin
      last_sel <= dv.sel;
      gap <= dv.pulse ? 11'h001 : gap + 11'h001;
      seen <= seen | dv.pulse;
      // A code change in the pulse cycle itself still spoils the next gap
      sel_moved <= (dv.sel != last_sel) || (!dv.pulse && sel_moved);
    end
  end

  // Spacing is judged only when the code stood still since the last pulse
  a_div_period: assert property (@(posedge sys_clk)
    disable iff (!arst_n)
    clk_en && dv.pulse && seen && !sel_moved && dv.sel == last_sel
    |-> gap == (11'h004 << dv.sel))
    else $error("divided pulse spacing wrong");

  c_div_slowest: cover property (@(posedge sys_clk) disable iff (!arst_n)
    dv.sel == 3'h7 && dv.pulse && seen);

endmodule // srl_divider

// ===== src/srl_top.sv
`timescale 1ns/1ps
// **********************************************************************
// Set-reset latch unit
// **********************************************************************
module srl_top
  import srl_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic [SRL_ADDR_W-1:0] reg_addr,
  input wire logic [SRL_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [SRL_DATA_W-1:0] reg_rdata,
  input wire logic external_trigger_input,
  input wire logic cmp_one_synced_output,
  input wire logic cmp_two_synced_output,
  output logic true_output_pin,
  output logic inverted_output_pin
);

  // **********************************************************************
  // Register file
  // **********************************************************************
  // Primary control, pulse bits are never stored here
  logic [7:0] latch_control_primary;
  // Set and reset source enables
  logic [7:0] latch_source_enables;
  // One-cycle software pulses
  logic sw_set_pulse;
  logic sw_reset_pulse;

  // Address decode
  wire hit_ctrl = (reg_addr == SRL_ADDR_CTRL);
  wire hit_src = (reg_addr == SRL_ADDR_SRC);
  wire hit_stat = (reg_addr == SRL_ADDR_STAT);
  wire wr_ctrl = reg_wr && hit_ctrl;
  wire wr_src = reg_wr && hit_src;

  // Pulse requests; writing zero does nothing
  wire next_set_pulse = wr_ctrl && reg_wdata[SRL_B_PS];
  wire next_reset_pulse = wr_ctrl && reg_wdata[SRL_B_PR];

  // Field decode
  wire latch_enable = latch_control_primary[SRL_B_LEN];
  wire true_output_enable = latch_control_primary[SRL_B_QEN];
  wire inverted_output_enable = latch_control_primary[SRL_B_NQEN];
  wire pin_set_enable = latch_source_enables[SRL_B_PIN_SET];
  wire clock_set_enable = latch_source_enables[SRL_B_CLK_SET];
  wire cmp_two_set_enable = latch_source_enables[SRL_B_C2_SET];
  wire cmp_one_set_enable = latch_source_enables[SRL_B_C1_SET];
  wire pin_reset_enable = latch_source_enables[SRL_B_PIN_RST];
  wire clock_reset_enable = latch_source_enables[SRL_B_CLK_RST];
  wire cmp_two_reset_enable = latch_source_enables[SRL_B_C2_RST];
  wire cmp_one_reset_enable = latch_source_enables[SRL_B_C1_RST];

  // Control registers clear on every reset
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      latch_control_primary <= SRL_CTRL_RST;
      latch_source_enables <= SRL_SRC_RST;
    end
    else if (clk_en)
    begin
      // Pulse bit positions are held at zero
      if (wr_ctrl)
        latch_control_primary <= {reg_wdata[7:2], 2'b00};
      if (wr_src)
        latch_source_enables <= reg_wdata;
    end
  end

  // Pulses self-clear on the next cycle without a write
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sw_set_pulse <= 1'b0;
      sw_reset_pulse <= 1'b0;
    end
    else if (clk_en)
    begin
      sw_set_pulse <= next_set_pulse;
      sw_reset_pulse <= next_reset_pulse;
    end
  end

  // **********************************************************************
  // Input synchronisers
  // **********************************************************************
  // Pin and comparator levels arrive from outside this clock domain
  wire [2:0] raw_in = {cmp_two_synced_output, cmp_one_synced_output,
                       external_trigger_input};
  // Filtered levels: bit 0 trigger, bit 1 comparator one, bit 2 two
  logic [2:0] in_filt;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_sync
      // Stage 1 feeds only stage 2, never logic
      logic [SRL_SYNC_STAGES-1:0] stage;
      always_ff @(posedge sys_clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          stage <= 3'b000;
          in_filt[gi] <= 1'b0;
        end
        else if (clk_en)
        begin
          stage <= {stage[1:0], raw_in[gi]};
          // A change counts once stages two and three agree
          if (stage[1] == stage[2])
            in_filt[gi] <= stage[2];
        end
      end
    end
  endgenerate

  wire trig_lvl = in_filt[0];
  wire cmp_one_lvl = in_filt[1];
  wire cmp_two_lvl = in_filt[2];

  // **********************************************************************
  // Divided pulse clock
  // **********************************************************************
  srl_div_if div_bus ();
  assign div_bus.sel = latch_control_primary[SRL_B_DIV_HI:SRL_B_DIV_LO];

  srl_divider u_divider (
    .sys_clk (sys_clk),
    .arst_n (arst_n),
    .clk_en (clk_en),
    .dv (div_bus.div)
  );

  wire divided_pulse_clock = div_bus.pulse;

  // **********************************************************************
  // Latch core
  // **********************************************************************
  // Each enabled source contributes to the OR
  wire set_from_clk = clock_set_enable && divided_pulse_clock;
  wire rst_from_clk = clock_reset_enable && divided_pulse_clock;
  wire set_from_pin = pin_set_enable && trig_lvl;
  wire rst_from_pin = pin_reset_enable && trig_lvl;
  wire set_from_cmp = (cmp_one_set_enable && cmp_one_lvl)
                   || (cmp_two_set_enable && cmp_two_lvl);
  wire rst_from_cmp = (cmp_one_reset_enable && cmp_one_lvl)
                   || (cmp_two_reset_enable && cmp_two_lvl);

  // Sources are ignored while the latch is disabled
  wire set_in = latch_enable && (sw_set_pulse || set_from_clk
                || set_from_pin || set_from_cmp);
  wire reset_in = latch_enable && (sw_reset_pulse || rst_from_clk
                  || rst_from_pin || rst_from_cmp);

  // Stored state, left without reset value on purpose
  logic latch_state;
  // Reset dominates; inputs act at once, not at the next edge
  wire next_latch = reset_in ? 1'b0 : (set_in ? 1'b1 : latch_state);
  wire q_now = next_latch;

  // No reset term: state stays unknown until a set or reset input acts
  always_ff @(posedge sys_clk)
  begin
    if (clk_en)
      latch_state <= next_latch;
  end

  // **********************************************************************
  // Outputs
  // **********************************************************************
  // Enables clear at reset, so pins read low even with unknown state
  assign true_output_pin = latch_enable && true_output_enable
                           && q_now;
  assign inverted_output_pin = latch_enable && inverted_output_enable
                               && !q_now;

  // Read mux; unmapped addresses read zero
  wire [7:0] stat_word = {3'b000, divided_pulse_clock, cmp_two_lvl,
                          cmp_one_lvl, trig_lvl, q_now};
  wire [7:0] rd_mux = hit_ctrl ? latch_control_primary :
                      hit_src ? latch_source_enables :
                      hit_stat ? stat_word : 8'h00;

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      reg_rdata <= 8'h00;
    else if (clk_en)
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
  end

  // **********************************************************************
  // Checks
  // **********************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  // Helper: first cycle after reset release
  logic first_cyc;
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      first_cyc <= 1'b1;
    else
      first_cyc <= 1'b0;
  end

  // Helper: set once the latch has seen a set or a reset; until then
  // its state is unknown on purpose and no check may judge it
  logic known_q;
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      known_q <= 1'b0;
    else if (clk_en && (set_in || reset_in))
      known_q <= 1'b1;
  end

  // **********************************************************************
  // Latch core checks
  // **********************************************************************
  // Reset input wins whatever the set sources say
  a_reset_dominates: assert property (reset_in |-> !q_now)
    else $error("reset did not dominate set");
  // With both inputs quiet the latch keeps its value
  a_state_holds: assert property (
    known_q && clk_en && !set_in && !reset_in
    ##1 !set_in && !reset_in |-> q_now == $past(q_now))
    else $error("latch lost its state");
  // A disabled latch sees no source at all
  a_disabled_ignores: assert property (
    !latch_enable |-> !set_in && !reset_in)
    else $error("source acted while latch disabled");
  // Only enabled sources reach the set input
  a_no_stray_set: assert property (
    latch_enable && !sw_set_pulse && !set_from_clk && !set_from_pin
    && !set_from_cmp |-> !set_in)
    else $error("set input high with no enabled source");

  // **********************************************************************
  // Software pulse checks
  // **********************************************************************
  // A written one shows as a pulse on the next cycle
  a_pulse_raise: assert property (
    clk_en && next_set_pulse |=> sw_set_pulse && set_in == latch_enable)
    else $error("set pulse missing");
  a_reset_raise: assert property (
    clk_en && next_reset_pulse
    |=> sw_reset_pulse && reset_in == latch_enable)
    else $error("reset pulse missing");
  // Without a fresh write the pulse drops again
  a_pulse_self_clear: assert property (
    clk_en && !next_reset_pulse |=> !sw_reset_pulse)
    else $error("reset pulse did not self clear");
  a_set_self_clear: assert property (
    clk_en && !next_set_pulse |=> !sw_set_pulse)
    else $error("set pulse did not self clear");
  // Pulse bit positions never read back as one
  a_pulse_reads_zero: assert property (
    clk_en && reg_rd && hit_ctrl |=> reg_rdata[1:0] == 2'b00)
    else $error("pulse bits read nonzero");

  // **********************************************************************
  // Source checks
  // **********************************************************************
  // Divided pulse sets or resets only through its own enable
  a_clock_sets: assert property (
    latch_enable && set_from_clk && !reset_in |-> q_now)
    else $error("divided pulse did not set");
  a_clock_resets: assert property (
    latch_enable && rst_from_clk |-> !q_now)
    else $error("divided pulse did not reset");
  // Trigger pin acts through its own enables
  a_pin_sets: assert property (
    latch_enable && pin_set_enable && trig_lvl && !reset_in |-> q_now)
    else $error("trigger did not set");
  a_pin_resets: assert property (
    latch_enable && pin_reset_enable && trig_lvl |-> !q_now)
    else $error("trigger did not reset");
  // Each comparator acts through its own enables
  a_cmp_sets: assert property (
    latch_enable && cmp_two_set_enable && cmp_two_lvl && !reset_in
    |-> q_now)
    else $error("comparator did not set");
  a_cmp_one_sets: assert property (
    latch_enable && cmp_one_set_enable && cmp_one_lvl && !reset_in
    |-> q_now)
    else $error("comparator one did not set");
  a_cmp_resets: assert property (
    latch_enable && cmp_one_reset_enable && cmp_one_lvl |-> !q_now)
    else $error("comparator did not reset");
  a_cmp_two_resets: assert property (
    latch_enable && cmp_two_reset_enable && cmp_two_lvl |-> !q_now)
    else $error("comparator two did not reset");

  // **********************************************************************
  // Output checks
  // **********************************************************************
  // Enabled pins carry the state and its complement
  a_outputs_follow: assert property (
    latch_enable && true_output_enable && inverted_output_enable
    |-> true_output_pin != inverted_output_pin)
    else $error("outputs not complementary");
  a_true_follows: assert property (
    known_q && latch_enable && true_output_enable
    |-> true_output_pin == q_now)
    else $error("true output does not carry the state");
  a_inv_follows: assert property (
    known_q && latch_enable && inverted_output_enable
    |-> inverted_output_pin == !q_now)
    else $error("inverted output does not carry the state");
  // Cleared enables keep the pins low
  a_outputs_off: assert property (
    !latch_enable || !true_output_enable |-> !true_output_pin)
    else $error("true output active while disabled");
  a_inv_off: assert property (
    !latch_enable || !inverted_output_enable |-> !inverted_output_pin)
    else $error("inverted output active while disabled");
  // Both registers and pins start cleared after every reset
  a_regs_cleared: assert property (
    first_cyc
    |-> latch_control_primary == 8'h00 && latch_source_enables == 8'h00
    && !true_output_pin && !inverted_output_pin)
    else $error("control registers not cleared");

  // Main scenarios
  c_sw_set: cover property (sw_set_pulse && latch_enable ##1 q_now);
  c_sw_reset: cover property (sw_reset_pulse && latch_enable);
  c_both_outputs: cover property (true_output_pin ##[1:20]
    inverted_output_pin);
  c_clock_reset: cover property (rst_from_clk && latch_enable);

endmodule // srl_top

// ===== dv/srl_far_model.sv
`timescale 1ns/1ps
// **********************************************************************
// Far side: trigger pin and comparator levels
// **********************************************************************
module srl_far_model
(
  input wire logic sys_clk,
  input wire logic [2:0] lvl_req, // Wanted levels: trig, cmp one, cmp two
  output logic trig,
  output logic cmp_one,
  output logic cmp_two
);
  // Levels move just after an edge; they are async to the unit anyway
  always_ff @(posedge sys_clk)
  begin
    trig <= lvl_req[0];
    cmp_one <= lvl_req[1];
    cmp_two <= lvl_req[2];
  end
endmodule // srl_far_model

// ===== dv/srl_top_tb.sv
`timescale 1ns/1ps
// **********************************************************************
// Self-checking bench for the set-reset latch unit
// **********************************************************************
module srl_top_tb;
  import srl_pkg::*;
  logic sys_clk, arst_n, reg_wr, reg_rd, tpin, ipin, trig, c1, c2, ce;
  logic [1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, d, en;
  logic [2:0] lv, rl;
  logic q;
  int seed, n_mismatch, n_checks, k;

  srl_top uut (.sys_clk(sys_clk), .arst_n(arst_n), .clk_en(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .external_trigger_input(trig), .cmp_one_synced_output(c1),
    .cmp_two_synced_output(c2), .true_output_pin(tpin),
    .inverted_output_pin(ipin));
  srl_far_model far (.sys_clk(sys_clk), .lvl_req(lv), .trig(trig),
    .cmp_one(c1), .cmp_two(c2));

  // Free-running 200 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Expected latch: any enabled reset wins, then any enabled set
  function automatic logic exp_q(logic [7:0] e, logic [2:0] l, logic p);
    logic s, r;
    s = e[SRL_B_PIN_SET] & l[0] | e[SRL_B_C1_SET] & l[1]
      | e[SRL_B_C2_SET] & l[2];
    r = e[SRL_B_PIN_RST] & l[0] | e[SRL_B_C1_RST] & l[1]
      | e[SRL_B_C2_RST] & l[2];
    return r ? 1'b0 : (s ? 1'b1 : p);
  endfunction

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] s, e);
    n_checks++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  // Pins are sampled mid-cycle, where they have settled
  task automatic chk_pins(input string n, input logic [1:0] e);
    @(negedge sys_clk);
    chk(n, {14'h0, ipin, tpin}, {14'h0, e});
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data is only valid in the cycle after the strobe
  task automatic rd(input logic [1:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    v = reg_rdata;
  endtask

  // Bounded wait for the true pin to reach a level; counts cycles
  task automatic wait_pin(input logic l, output int c);
    c = 0;
    do
    begin
      @(negedge sys_clk);
      c++;
    end while (tpin !== l && c < 1100);
    if (c >= 1100)
    begin
      n_mismatch++;
      $display("mismatch wait_pin expected %b seen timeout", l);
      close_out();
    end
  endtask

  initial
  begin
    seed = 32'h09bf8277;
    n_mismatch = 0;
    n_checks = 0;
    arst_n = 1'b0;
    ce = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 2'h0;
    reg_wdata = 8'h00;
    lv = 3'h0;
    tick(16);
    arst_n <= 1'b1;
    // Reset values and the unmapped index
    rd(SRL_ADDR_CTRL, d);
    chk("ctrl_reset", d, SRL_CTRL_RST);
    rd(SRL_ADDR_SRC, d);
    chk("src_reset", d, SRL_SRC_RST);
    wr(2'h3, 8'hFF);
    rd(2'h3, d);
    chk("unmapped", d, 8'h00);
    $display("test reset_values done");
    // Known state first, outputs enabled only afterwards
    wr(SRL_ADDR_CTRL, 8'h81);
    wr(SRL_ADDR_CTRL, 8'h8E);
    chk_pins("sw_set", 2'b01);
    tick(3);
    chk_pins("hold", 2'b01);
    rd(SRL_ADDR_CTRL, d);
    chk("pulse_bits_read", d, 8'h8C);
    // Read data stands one cycle only, then drops back to zero
    @(negedge sys_clk);
    chk("rdata_idle", reg_rdata, 8'h00);
    // A stuck set pulse would set again once the trigger drops
    wr(SRL_ADDR_SRC, 8'h08);
    lv <= 3'b001;
    tick(6);
    chk_pins("pin_reset", 2'b10);
    // Status: state low, trigger high; divided pulse bit is free-running
    rd(SRL_ADDR_STAT, d);
    chk("status", d & 8'hEF, 8'h02);
    lv <= 3'b000;
    tick(6);
    chk_pins("pulse_cleared", 2'b10);
    wr(SRL_ADDR_SRC, 8'h00);
    wr(SRL_ADDR_CTRL, 8'h8E);
    wr(SRL_ADDR_CTRL, 8'h8F);
    chk_pins("both_pulses", 2'b10);
    $display("test software_pulses done");
    // Random source enables and levels; first case is trigger on both
    q = 1'b0;
    for (int i = 0; i < 40; i++)
    begin
      en = (i == 0) ? 8'h88 : 8'($random(seed)) & 8'hBB;
      rl = (i == 0) ? 3'b001 : 3'($random(seed));
      lv <= 3'b000;
      tick(6);
      wr(SRL_ADDR_SRC, en);
      lv <= rl;
      tick(6);
      q = exp_q(en, rl, q);
      chk_pins("src", {~q, q});
    end
    $display("test random_sources done");
    // Trigger holds set; divided pulse resets for one cycle per period
    lv <= 3'b000;
    tick(6);
    wr(SRL_ADDR_SRC, 8'h84);
    lv <= 3'b001;
    tick(6);
    for (int c = 0; c < 8; c++)
    begin
      wr(SRL_ADDR_CTRL, {1'b1, 3'(c), 4'hC});
      wait_pin(1'b0, k);
      wait_pin(1'b0, k);
      chk("div_period", 16'(k), 16'(4 << c));
      chk_pins("div_width", 2'b01);
    end
    // Cleared clock reset enable blocks the path
    wr(SRL_ADDR_SRC, 8'h80);
    k = 0;
    repeat (1100)
    begin
      @(negedge sys_clk);
      if (tpin !== 1'b1)
        k++;
    end
    chk("blocked_lows", 16'(k), 16'h0000);
    lv <= 3'b000;
    wr(SRL_ADDR_SRC, 8'h40);
    wr(SRL_ADDR_CTRL, 8'h8D);
    wait_pin(1'b1, k);
    chk_pins("clock_set", 2'b01);
    $display("test divider done");
    // Disabled latch or output enable keeps pins low
    wr(SRL_ADDR_SRC, 8'h00);
    wr(SRL_ADDR_CTRL, 8'h0C);
    chk_pins("latch_off", 2'b00);
    wr(SRL_ADDR_CTRL, 8'h84);
    chk_pins("true_off", 2'b00);
    wr(SRL_ADDR_CTRL, 8'h88);
    chk_pins("inv_off", 2'b01);
    $display("test output_enables done");
    // Mid-run reset clears both registers and drops the pins
    tick(1);
    arst_n <= 1'b0;
    tick(2);
    arst_n <= 1'b1;
    chk_pins("reset_pins", 2'b00);
    rd(SRL_ADDR_CTRL, d);
    chk("ctrl_rerun", d, SRL_CTRL_RST);
    // A write while the clock enable is low must not be taken
    tick(1);
    ce <= 1'b0;
    wr(SRL_ADDR_SRC, 8'hFF);
    ce <= 1'b1;
    rd(SRL_ADDR_SRC, d);
    chk("frozen_write", d, SRL_SRC_RST);
    $display("test reset_and_freeze done");
    close_out();
  end
endmodule // srl_top_tb
